// ### hw/updown_counter.sv
// Cascadable up/down counter chain with request front end and AXI4-Lite registers
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module updown_counter #(
  parameter int unsigned STAGES = 2,
  parameter bit          DECADE = 1'b1
) (
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  input  wire logic                             up_req,
  input  wire logic                             down_req,
  output logic [4*STAGES-1:0]                   count_out,
  output logic                                  carry_up_out_n,
  output logic                                  borrow_down_out_n,
  output logic                                  div_half_out,
  input  wire logic [updown_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                             s_axi_awvalid,
  output logic                                  s_axi_awready,
  input  wire logic [31:0]                      s_axi_wdata,
  input  wire logic [3:0]                       s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output logic                                  s_axi_wready,
  output logic [1:0]                            s_axi_bresp,
  output logic                                  s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  input  wire logic [updown_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                             s_axi_arvalid,
  output logic                                  s_axi_arready,
  output logic [31:0]                           s_axi_rdata,
  output logic [1:0]                            s_axi_rresp,
  output logic                                  s_axi_rvalid,
  input  wire logic                             s_axi_rready
);
  localparam int unsigned CW = 4 * STAGES;

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  if (STAGES < 1 || STAGES > updown_pkg::MAX_STAGES) begin : g_bad
    $error("STAGES must be 1 to 8");
  end

  // ---------------------------------------------------------------
  // Digit arithmetic
  // ---------------------------------------------------------------
  // Highest digit state for the chosen sequence
  function automatic logic [3:0] dmax();
    return DECADE ? updown_pkg::DEC_MAX : updown_pkg::BIN_MAX;
  endfunction

  // Whole chain at its top state; binary limit is all fifteens
  function automatic logic [CW-1:0] chain_max();
    logic [CW-1:0] v;
    v = '0;
    for (int i = 0; i < STAGES; i++) begin
      v[4*i +: 4] = dmax();
    end
    return v;
  endfunction

  // Ripple step: a digit moves only when every lower digit sat at its limit
  function automatic logic [CW-1:0] step(input logic [CW-1:0] c, input logic up);
    logic [CW-1:0] v;
    logic          go;
    logic [3:0]    d;
    v  = c;
    go = 1'b1;
    for (int i = 0; i < STAGES; i++) begin
      d = c[4*i +: 4];
      if (go) begin
        if (up) begin
          v[4*i +: 4] = (d == dmax()) ? 4'h0 : d + 4'h1;
        end else begin
          v[4*i +: 4] = (d == 4'h0) ? dmax() : d - 4'h1;
        end
      end
      go = go && (up ? (d == dmax()) : (d == 4'h0));
    end
    return v;
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] v;
    v = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        v[8*b +: 8] = n[8*b +: 8];
      end
    end
    return v;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]                    up_sr;
    logic [1:0]                    dn_sr;
    logic                          up_pulse;
    logic                          dn_pulse;
    logic [CW-1:0]                 count;
    logic                          toggle;
    logic [1:0]                    mode;
    logic                          clear;
    logic                          load;
    logic [CW-1:0]                 preset;
    logic                          aw_got;
    logic                          w_got;
    logic [updown_pkg::ADDR_W-1:0] awaddr;
    logic [31:0]                   wdata;
    logic [3:0]                    wstrb;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          rvalid;
    logic [1:0]                    rresp;
    logic [31:0]                   rdata;
  } state_t;

  state_t st_reg;
  state_t st_next;

  // ---------------------------------------------------------------
  // Terminal outputs of every stage
  // ---------------------------------------------------------------
  // A stage's count clock is low while its lower neighbour's terminal is low
  logic [STAGES:0]   up_low;
  logic [STAGES:0]   dn_low;
  logic [STAGES-1:0] carry_n;
  logic [STAGES-1:0] borrow_n;
  assign up_low[0] = st_reg.up_pulse;
  assign dn_low[0] = st_reg.dn_pulse;
  for (genvar i = 0; i < STAGES; i++) begin : g_stage
    assign carry_n[i]    = ~(up_low[i] && st_reg.count[4*i +: 4] == dmax());
    assign borrow_n[i]   = ~(dn_low[i] && st_reg.count[4*i +: 4] == 4'h0);
    assign up_low[i + 1] = ~carry_n[i];
    assign dn_low[i + 1] = ~borrow_n[i];
  end

  // Chain terminals feed the limiting and reload paths for any length
  logic chain_carry;
  logic chain_borrow;
  assign chain_carry  = up_low[STAGES];
  assign chain_borrow = dn_low[STAGES];

  // ---------------------------------------------------------------
  // Request front end and counter
  // ---------------------------------------------------------------
  logic up_rise;
  logic dn_rise;
  logic wr_fire;
  logic ar_fire;
  assign up_rise = ~st_reg.up_sr[1] & st_reg.up_sr[0];
  assign dn_rise = ~st_reg.dn_sr[1] & st_reg.dn_sr[0];
  assign s_axi_awready = ~st_reg.aw_got & ~st_reg.bvalid;
  assign s_axi_wready  = ~st_reg.w_got & ~st_reg.bvalid;
  assign s_axi_arready = ~st_reg.rvalid;
  assign ar_fire = s_axi_arvalid & s_axi_arready;
  assign wr_fire = st_reg.aw_got & st_reg.w_got & ~st_reg.bvalid;

  // All state advances on aclk, so outputs only move on master clock edges
  always_comb begin
    st_next = st_reg;
    // Two-bit history per request line
    st_next.up_sr = {st_reg.up_sr[0], up_req};
    st_next.dn_sr = {st_reg.dn_sr[0], down_req};
    // Coincident rises cancel each other
    st_next.up_pulse = up_rise & ~dn_rise;
    st_next.dn_pulse = dn_rise & ~up_rise;
    // Count: clear beats load beats clocks
    if (st_reg.clear) begin
      st_next.count = '0;
    end else if (st_reg.load) begin
      st_next.count = st_reg.preset;
    end else begin
      case (st_reg.mode)
        updown_pkg::MODE_DIV: begin
          // Reload happens in the low phase, decrement on the rising edge
          if (chain_borrow) begin
            st_next.count  = step(st_reg.preset, 1'b0);
            st_next.toggle = ~st_reg.toggle;
          end else if (st_reg.dn_pulse) begin
            st_next.count = step(st_reg.count, 1'b0);
          end
        end
        updown_pkg::MODE_LIMIT: begin
          if (chain_borrow) begin
            st_next.count = '0;
          end else if (chain_carry) begin
            st_next.count = chain_max();
          end else if (st_reg.up_pulse || st_reg.dn_pulse) begin
            st_next.count = step(st_reg.count, st_reg.up_pulse);
          end
        end
        default: begin
          // Free running; code 2'b11 also lands here
          if (st_reg.up_pulse || st_reg.dn_pulse) begin
            st_next.count = step(st_reg.count, st_reg.up_pulse);
          end
        end
      endcase
    end
    // Write address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_got = 1'b1;
      st_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_got = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end
    if (wr_fire) begin
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = updown_pkg::RESP_OKAY;
      case ({st_reg.awaddr[updown_pkg::ADDR_W-1:2], 2'b00})
        updown_pkg::CTRL_OFF: begin
          if (st_reg.wstrb[0]) begin
            st_next.mode  = st_reg.wdata[updown_pkg::CTRL_MODE_LSB +: 2];
            st_next.clear = st_reg.wdata[updown_pkg::CTRL_CLEAR];
            st_next.load  = st_reg.wdata[updown_pkg::CTRL_LOAD];
          end
        end
        updown_pkg::PRESET_OFF: begin
          st_next.preset = CW'(merge(32'(st_reg.preset), st_reg.wdata, st_reg.wstrb));
        end
        updown_pkg::COUNT_OFF, updown_pkg::STATUS_OFF: begin
          st_next.bresp = updown_pkg::RESP_OKAY;
        end
        default: begin
          st_next.bresp = updown_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    // Read data is captured at the address handshake
    if (ar_fire) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = updown_pkg::RESP_OKAY;
      case ({s_axi_araddr[updown_pkg::ADDR_W-1:2], 2'b00})
        updown_pkg::CTRL_OFF: begin
          st_next.rdata = {28'h0, st_reg.load, st_reg.clear, st_reg.mode};
        end
        updown_pkg::PRESET_OFF: begin
          st_next.rdata = 32'(st_reg.preset);
        end
        updown_pkg::COUNT_OFF: begin
          st_next.rdata = 32'(st_reg.count);
        end
        updown_pkg::STATUS_OFF: begin
          st_next.rdata = {29'h0, st_reg.toggle, borrow_n[STAGES-1], carry_n[STAGES-1]};
        end
        default: begin
          st_next.rdata = 32'h0;
          st_next.rresp = updown_pkg::RESP_SLVERR;
        end
      endcase
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
  end

  // Single state register, synchronous active-low reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg      <= '0;
      st_reg.mode <= updown_pkg::CTRL_MODE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign count_out         = st_reg.count;
  assign carry_up_out_n    = carry_n[STAGES-1];
  assign borrow_down_out_n = borrow_n[STAGES-1];
  assign div_half_out      = st_reg.toggle;
  assign s_axi_bvalid      = st_reg.bvalid;
  assign s_axi_bresp       = st_reg.bresp;
  assign s_axi_rvalid      = st_reg.rvalid;
  assign s_axi_rresp       = st_reg.rresp;
  assign s_axi_rdata       = st_reg.rdata;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic quiet;
  assign quiet = ~st_reg.clear & ~st_reg.load;

  sequence up_rise_s;
    !st_reg.up_sr[1] && st_reg.up_sr[0] && !dn_rise;
  endsequence
  sequence dn_rise_s;
    !st_reg.dn_sr[1] && st_reg.dn_sr[0] && !up_rise;
  endsequence

  both_rise_drop_a: assert property (up_rise && dn_rise |=> !st_reg.up_pulse && !st_reg.dn_pulse)
    else $error("coincident requests produced a count pulse");
  up_pulse_once_a: assert property (up_rise_s |=> st_reg.up_pulse ##1 !st_reg.up_pulse)
    else $error("up rise did not give one pulse");
  dn_pulse_once_a: assert property (dn_rise_s |=> st_reg.dn_pulse ##1 !st_reg.dn_pulse)
    else $error("down rise did not give one pulse");
  carry_cause_a: assert property (!carry_up_out_n |-> st_reg.up_pulse && st_reg.count == chain_max())
    else $error("carry low without top state and up clock");
  borrow_cause_a: assert property (!borrow_down_out_n |-> st_reg.dn_pulse && st_reg.count == '0)
    else $error("borrow low without zero and down clock");
  wrap_up_a: assert property (quiet && st_reg.mode == updown_pkg::MODE_FREE && st_reg.up_pulse
                              && st_reg.count == chain_max() |=> st_reg.count == '0)
    else $error("free counter did not wrap from top");
  limit_hold_a: assert property (quiet && st_reg.mode == updown_pkg::MODE_LIMIT
                                 && (chain_carry || chain_borrow) |=> $stable(st_reg.count))
    else $error("limited counter left its end state");
  div_reload_a: assert property (quiet && st_reg.mode == updown_pkg::MODE_DIV && chain_borrow
                                 |=> st_reg.count == step($past(st_reg.preset), 1'b0)
                                     && st_reg.toggle != $past(st_reg.toggle))
    else $error("divider did not reload and toggle");
  clear_wins_a: assert property (st_reg.clear |=> st_reg.count == '0)
    else $error("clear did not hold count at zero");
endmodule

// ### hw/updown_pkg.sv
// Constants shared by the cascadable up/down counter block
package updown_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W      = 4;
  localparam logic [3:0]  CTRL_OFF    = 4'h0;
  localparam logic [3:0]  PRESET_OFF  = 4'h4;
  localparam logic [3:0]  COUNT_OFF   = 4'h8;
  localparam logic [3:0]  STATUS_OFF  = 4'hc;
  // ---------------------------------------------------------------
  // Control fields
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_CLEAR    = 2;
  localparam int unsigned CTRL_LOAD     = 3;
  localparam logic [1:0]  CTRL_MODE_RST = 2'h0;
  // Status fields
  localparam int unsigned STAT_CARRY_N  = 0;
  localparam int unsigned STAT_BORROW_N = 1;
  localparam int unsigned STAT_HALF     = 2;
  // ---------------------------------------------------------------
  // Operating modes and bus answers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_FREE  = 2'b00,
    MODE_DIV   = 2'b01,
    MODE_LIMIT = 2'b10
  } mode_t;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // Digit limits
  localparam logic [3:0]  DEC_MAX     = 4'h9;
  localparam logic [3:0]  BIN_MAX     = 4'hf;
  localparam int unsigned MAX_STAGES  = 8;
endpackage

// ### test/count_source.sv
// Far-side model: aclk-clocked request source and next cascaded stage
`timescale 1ns/1ps
module count_source (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       send_up,
  input  wire logic       send_down,
  input  wire logic       carry_up_out_n,
  input  wire logic       borrow_down_out_n,
  output logic            up_req,
  output logic            down_req,
  output logic [7:0]      ups_seen,
  output logic [7:0]      downs_seen
);
  logic [2:0] phase;
  // ---------------------------------------------------------------
  // Request lines
  // ---------------------------------------------------------------
  // High level held two cycles, low at least three; faster toggling would lose edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase    <= 3'h0;
      up_req   <= 1'b0;
      down_req <= 1'b0;
    end else if (phase != 3'h0) begin
      phase <= (phase == 3'h4) ? 3'h0 : phase + 3'h1;
      if (phase == 3'h2) begin
        up_req   <= 1'b0;
        down_req <= 1'b0;
      end
    end else if (send_up || send_down) begin
      up_req   <= send_up;
      down_req <= send_down;
      phase    <= 3'h1;
    end
  end
  // ---------------------------------------------------------------
  // Next stage
  // ---------------------------------------------------------------
  // One count per cycle its clock is held low, so long pulses show up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ups_seen   <= 8'h00;
      downs_seen <= 8'h00;
    end else begin
      if (!carry_up_out_n) ups_seen <= ups_seen + 8'h01;
      if (!borrow_down_out_n) downs_seen <= downs_seen + 8'h01;
    end
  end
endmodule

// ### test/cascadable_up_down_counter_test.sv
// Self-checking bench for the cascadable up/down counter
`timescale 1ns/1ps
module cascadable_up_down_counter_test;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        send_up = 1'b0;
  logic        send_down = 1'b0;
  logic        up_req, down_req, carry_n, borrow_n, half;
  logic [7:0]  count_out, ups, downs;
  logic [3:0]  awaddr = 4'h0;
  logic [3:0]  araddr = 4'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, rd;
  logic [7:0]  base;
  logic        h0;
  int          errors = 0;
  int          check_count = 0;
  always #2.5 aclk = ~aclk;
  updown_counter #(.STAGES(2), .DECADE(1'b1)) uut (
    .aclk(aclk), .aresetn(aresetn), .up_req(up_req), .down_req(down_req), .count_out(count_out),
    .carry_up_out_n(carry_n), .borrow_down_out_n(borrow_n), .div_half_out(half),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  count_source far_end (
    .aclk(aclk), .aresetn(aresetn), .send_up(send_up), .send_down(send_down), .carry_up_out_n(carry_n),
    .borrow_down_out_n(borrow_n), .up_req(up_req), .down_req(down_req), .ups_seen(ups), .downs_seen(downs));
  // ---------------------------------------------------------------
  // Reporting
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  // Every wait is bounded; a hang ends the run as a mismatch
  task automatic tick(inout int n);
    n++;
    if (n > 100) begin
      errors++;
      stop_test();
    end
  endtask
  // ---------------------------------------------------------------
  // Bus and pin drivers
  // ---------------------------------------------------------------
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
    int   n;
    logic ad, wd, ga, gw, got;
    n = 0;
    ad = 1'b0;
    wd = 1'b0;
    ga = 1'b0;
    gw = 1'b0;
    got = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Both readies looked at mid-cycle, where they are settled
    while (!(ad && wd)) begin
      @(negedge aclk);
      ga = !ad && awready === 1'b1;
      gw = !wd && wready === 1'b1;
      @(posedge aclk);
      if (ga) awvalid <= 1'b0;
      if (gw) wvalid <= 1'b0;
      ad = ad || ga;
      wd = wd || gw;
      tick(n);
    end
    got = 1'b0;
    while (!got) begin
      @(negedge aclk);
      got = bvalid === 1'b1;
      @(posedge aclk);
      tick(n);
    end
    bready <= 1'b0;
    chk(updown_pkg::RESP_OKAY, bresp);
  endtask
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
    int   n;
    logic got;
    n = 0;
    got = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(negedge aclk);
      got = arready === 1'b1;
      @(posedge aclk);
      tick(n);
    end
    arvalid <= 1'b0;
    got = 1'b0;
    while (!got) begin
      @(negedge aclk);
      got = rvalid === 1'b1;
      d = rdata;
      @(posedge aclk);
      tick(n);
    end
    rready <= 1'b0;
    chk(updown_pkg::RESP_OKAY, rresp);
  endtask
  // Control takes effect one edge after the write answer; wait past it
  task automatic ctrl(input logic [31:0] v);
    axi_write(updown_pkg::CTRL_OFF, v);
    @(negedge aclk);
  endtask
  // One request through the far-side source; count settles well inside the wait
  task automatic send(input logic u, input logic d);
    @(posedge aclk);
    send_up <= u;
    send_down <= d;
    @(posedge aclk);
    send_up <= 1'b0;
    send_down <= 1'b0;
    repeat (6) @(posedge aclk);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    axi_read(updown_pkg::STATUS_OFF, rd);
    chk(32'h3, rd);
    axi_write(updown_pkg::COUNT_OFF, 32'h55);
    axi_read(updown_pkg::COUNT_OFF, rd);
    chk(32'h0, rd);
    axi_write(updown_pkg::PRESET_OFF, 32'h12345678);
    axi_read(updown_pkg::PRESET_OFF, rd);
    chk(32'h78, rd);
    $display("regs done");
  endtask
  task automatic t_up();
    for (int i = 0; i < 11; i++) send(1'b1, 1'b0);
    chk(8'h11, count_out);
    chk(8'h00, ups);
    $display("cascade up done");
  endtask
  task automatic t_top();
    axi_write(updown_pkg::PRESET_OFF, 32'h99);
    ctrl(32'h8);
    ctrl(32'h0);
    chk(8'h99, count_out);
    base = ups;
    send(1'b1, 1'b0);
    chk(base + 8'h01, ups);
    chk(8'h00, count_out);
    base = downs;
    send(1'b0, 1'b1);
    chk(base + 8'h01, downs);
    chk(8'h99, count_out);
    base = ups;
    send(1'b1, 1'b1);
    chk(8'h99, count_out);
    chk(base, ups);
    $display("terminals done");
  endtask
  task automatic t_div();
    axi_write(updown_pkg::PRESET_OFF, 32'h3);
    ctrl(32'h4);
    ctrl(32'h1);
    h0 = half;
    send(1'b0, 1'b1);
    chk(8'h02, count_out);
    chk({31'h0, ~h0}, half);
    send(1'b1, 1'b0);
    chk(8'h02, count_out);
    for (int i = 0; i < 3; i++) send(1'b0, 1'b1);
    chk(8'h02, count_out);
    chk(h0, half);
    $display("divider done");
  endtask
  task automatic t_limit();
    ctrl(32'h4);
    ctrl(32'h2);
    send(1'b0, 1'b1);
    chk(8'h00, count_out);
    axi_write(updown_pkg::PRESET_OFF, 32'h99);
    ctrl(32'ha);
    ctrl(32'h2);
    send(1'b1, 1'b0);
    chk(8'h99, count_out);
    $display("limit done");
  endtask
  task automatic t_prio();
    axi_write(updown_pkg::PRESET_OFF, 32'h42);
    ctrl(32'hc);
    chk(8'h00, count_out);
    ctrl(32'h8);
    chk(8'h42, count_out);
    send(1'b1, 1'b0);
    chk(8'h42, count_out);
    ctrl(32'h0);
    $display("priority done");
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_up();
    t_top();
    t_div();
    t_limit();
    t_prio();
    stop_test();
  end
endmodule
